// ---- bench/dsc_checker.sv ----
// concurrent checks on the command decoder ports
`timescale 1ns/1ps
`default_nettype none

module dsc_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic chip_select_n,
    input wire logic sdo_oe,
    input wire logic [15:0] code_out,
    input wire logic [15:0] preload_out,
    input wire logic write_block,
    input wire logic powerdown_float,
    input wire logic pulldown_powerdown_select,
    input wire logic code_update,
    input wire logic cmd_reject,
    input wire logic frame_short
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // ----------------------------------------------------------------
    // link side and pulses
    // ----------------------------------------------------------------
    a_oe_idle: assert property ($past(chip_select_n) && chip_select_n |-> !sdo_oe)
        else $error("serial output driven while deselected");
    a_oe_frame: assert property ($rose(sdo_oe) |-> !chip_select_n)
        else $error("serial output enabled outside a frame");
    a_update_pulse: assert property (code_update |=> !code_update)
        else $error("update pulse longer than one cycle");
    a_reject_pulse: assert property (cmd_reject |=> !cmd_reject)
        else $error("reject pulse longer than one cycle");
    a_short_pulse: assert property (frame_short |=> !frame_short)
        else $error("short frame pulse longer than one cycle");
    // commands act only after the frame has closed
    a_answer_late: assert property ((code_update || cmd_reject) |->
        $past(chip_select_n, 2) && $past(chip_select_n, 3))
        else $error("command acted before the frame closed");

    // ----------------------------------------------------------------
    // register outputs
    // ----------------------------------------------------------------
    a_pd_excl: assert property (!(powerdown_float && pulldown_powerdown_select))
        else $error("both power-down kinds active");
    a_code_cause: assert property ($changed(code_out) |-> code_update)
        else $error("output changed without update pulse");
    a_frame_quiet: assert property ((!chip_select_n)[*8] |->
        $stable(code_out) && $stable(write_block) && $stable(powerdown_float))
        else $error("registers changed inside a frame");
    a_write_thru: assert property ($changed(preload_out) && !write_block |->
        code_out == preload_out)
        else $error("write-through store left output behind");
endmodule

bind dsc_command_decoder dsc_checker dsc_checker_i (
    .clk(clk),
    .rst_n(rst_n),
    .chip_select_n(chip_select_n),
    .sdo_oe(sdo_oe),
    .code_out(code_out),
    .preload_out(preload_out),
    .write_block(write_block),
    .powerdown_float(powerdown_float),
    .pulldown_powerdown_select(pulldown_powerdown_select),
    .code_update(code_update),
    .cmd_reject(cmd_reject),
    .frame_short(frame_short)
);

`default_nettype wire

// ---- bench/dsc_command_decoder_test.sv ----
// self-checking testbench of the serial command decoder
`timescale 1ns/1ps
`default_nettype none

module dsc_command_decoder_test;
    logic clk, rst_n, sclk, chip_select_n, mosi, sdo, sdo_oe;
    logic [15:0] code_out, preload_out;
    logic write_block, powerdown_float, pulldown_powerdown_select;
    logic code_update, cmd_reject, frame_short, seen_upd, seen_rej, seen_short;
    logic [23:0] rsp;
    int errors = 0;
    int cmp_count = 0;

    dsc_command_decoder dsc_command_decoder_i (.clk(clk), .rst_n(rst_n), .sclk(sclk),
        .chip_select_n(chip_select_n), .mosi(mosi), .sdo(sdo), .sdo_oe(sdo_oe),
        .code_out(code_out), .preload_out(preload_out), .write_block(write_block),
        .powerdown_float(powerdown_float),
        .pulldown_powerdown_select(pulldown_powerdown_select),
        .code_update(code_update), .cmd_reject(cmd_reject), .frame_short(frame_short));
    dsc_host dsc_host_i (.sclk(sclk), .chip_select_n(chip_select_n), .mosi(mosi),
        .sdo(sdo), .sdo_oe(sdo_oe));

    // 20 MHz system clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // pulses are one cycle wide, so latch them for the checks
    always @(posedge clk) begin
        if (code_update === 1'b1) seen_upd <= 1'b1;
        if (cmd_reject === 1'b1) seen_rej <= 1'b1;
        if (frame_short === 1'b1) seen_short <= 1'b1;
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [15:0] cfg();
        return {13'h0000, write_block, pulldown_powerdown_select, powerdown_float};
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic f, input logic e);
        chk({15'h0000, f}, {15'h0000, e});
    endtask
    // one frame, then the quiet gap that also covers the answer latency
    task automatic cmd(input logic [7:0] c, input logic [15:0] p, input int n = 24);
        @(negedge clk);
        {seen_upd, seen_rej, seen_short} = 3'b000;
        dsc_host_i.xfer({c, p}, n, rsp);
        repeat (12) @(negedge clk);
    endtask
    // the answer to a read arrives in the following frame
    task automatic rd(input logic [7:0] c, input logic [15:0] e);
        cmd(c, 16'h0000);
        cmd(8'h00, 16'h0000);
        chk(rsp[15:0], e);
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        chk(code_out, 16'h0000);
        chk(cfg(), 16'h0004);
        rd(8'h90, 16'h0004);
        $display("reset defaults done");
    endtask
    task automatic t_block;
        cmd(8'h08, 16'h4000);
        chk(preload_out, 16'h4000);
        chk(code_out, 16'h0000);
        cmd(8'h18, 16'hfffe);
        chk(code_out, 16'h0000);
        cmd(8'h18, 16'h0001);
        chk(code_out, 16'h4000);
        chk1(seen_upd, 1'b1);
        $display("write-block done");
    endtask
    task automatic t_through;
        cmd(8'h28, 16'h00fe);
        chk(cfg(), 16'h0000);
        cmd(8'h08, 16'hffff);
        chk(code_out, 16'hffff);
        rd(8'h90, 16'h0000);
        $display("write-through done");
    endtask
    task automatic t_update;
        cmd(8'h28, 16'h0001);
        chk(cfg(), 16'h0004);
        cmd(8'h10, 16'h1234);
        chk(code_out, 16'h1234);
        cmd(8'h20, 16'h5678);
        chk(preload_out, 16'h5678);
        cmd(8'h09, 16'haaaa);
        chk(preload_out, 16'h5678);
        cmd(8'h08, 16'h2222);
        chk(code_out, 16'h5678);
        rd(8'h88, 16'h2222);
        rd(8'h98, 16'h5678);
        cmd(8'h80, 16'h0000);
        chk1(seen_rej, 1'b1);
        $display("store and read-back done");
    endtask
    task automatic t_power;
        cmd(8'h30, 16'h0100);
        chk(cfg(), 16'h0005);
        cmd(8'h30, 16'h0101);
        chk(cfg(), 16'h0006);
        cmd(8'h10, 16'h0bad);
        chk(code_out, 16'h0bad);
        rd(8'h90, 16'h0006);
        cmd(8'h30, 16'hfe00);
        chk(cfg(), 16'h0004);
        $display("power-down done");
    endtask
    task automatic t_clear;
        cmd(8'h28, 16'h0000);
        cmd(8'h30, 16'h0001);
        cmd(8'h00, 16'hffff);
        chk(cfg(), 16'h0002);
        chk1(seen_rej, 1'b0);
        cmd(8'h01, 16'hffff);
        chk(code_out, 16'h0000);
        chk(preload_out, 16'h0000);
        chk(cfg(), 16'h0004);
        $display("clear done");
    endtask
    task automatic t_short;
        cmd(8'h10, 16'h7777, 8);
        chk1(seen_short, 1'b1);
        chk(code_out, 16'h0000);
        cmd(8'h10, 16'h7777);
        chk(code_out, 16'h7777);
        $display("short frame done");
    endtask

    // ----------------------------------------------------------------
    // main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        rst_n = 1'b1;
        // a true fall clears the held link word and toggle
        #1 rst_n = 1'b0;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        t_reset();
        t_block();
        t_through();
        t_update();
        t_power();
        t_clear();
        t_short();
        test_done();
    end
    // about 31 frames of under 3 us each; allow ample margin
    initial begin
        #1000000;
        errors++;
        test_done();
    end
endmodule

`default_nettype wire

// ---- bench/dsc_host.sv ----
// host controller model that drives frames on the serial link
`timescale 1ns/1ps
`default_nettype none

module dsc_host (
    output logic sclk,
    output logic chip_select_n,
    output logic mosi,
    input wire logic sdo,
    input wire logic sdo_oe
);
    // link clock stands still between frames
    initial begin
        sclk = 1'b0;
        chip_select_n = 1'b0;
        mosi = 1'b0;
        // a true rise clears the frame flops held by select
        #1 chip_select_n = 1'b1;
    end

    // ----------------------------------------------------------------
    // frame of n bits, msb first, answer taken at each rising edge
    // ----------------------------------------------------------------
    task automatic xfer(input logic [23:0] w, input int n, output logic [23:0] r);
        r = 24'h000000;
        #40 chip_select_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            mosi = w[23 - i];
            #40 sclk = 1'b1;
            r[23 - i] = sdo_oe ? sdo : 1'b0;
            #40 sclk = 1'b0;
        end
        #40 chip_select_n = 1'b1;
        mosi = ~mosi; // released line must not echo the last bit
    endtask
endmodule

`default_nettype wire

// ---- design/dsc_command_decoder.sv ----
// command decoder of a single channel converter behind a serial link
// Functional notes
// RULE_01: word and read commands carry the channel index in the low three command bits.
// RULE_02: setup commands select channels by a payload bitmask, bit n for channel n.
// RULE_03: only channel 0 exists; other indices and mask bits are ignored.
// RULE_04: command 00h does nothing and 01h restores every register to its default.
// RULE_05: command 18h copies preload into output when mask bit 0 is set.
// RULE_06: command 28h sets write-block from mask bit 0, zero meaning write-through.
// RULE_07: after reset the mode mask is 00ffh, so channel 0 starts in write-block.
// RULE_08: command 30h powers down floating from the high byte, pulldown from the low, pulldown wins.
// RULE_09: a single store writes preload, and output too when in write-through.
// RULE_10: in write-through the output follows a single store with no load step.
// RULE_11: store-and-update and broadcast store write both registers whatever the mode.
// RULE_12: groups 10001, 10010 and 10011 read preload, setup and output; 10000 is reserved.
// RULE_13: setup read-back holds write-block in bit 2, pulldown in bit 1, floating in bit 0.
// RULE_14: the output changes when the frame closes, at the rise of chip select.
// RULE_15: link and registers stay live while powered down; a later command wakes the channel.
// RULE_16: a frame is 24 bits msb first: command, payload high, payload low.
// RULE_17: a read-back answer shifts out during the frame after the read.
`timescale 1ns/1ps
`default_nettype none

module dsc_command_decoder #(
    parameter logic [15:0] RESET_CODE = 16'h0000
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic chip_select_n,
    input wire logic mosi,
    output logic sdo,
    output logic sdo_oe,
    output logic [15:0] code_out,
    output logic [15:0] preload_out,
    output logic write_block,
    output logic powerdown_float,
    output logic pulldown_powerdown_select,
    output logic code_update,
    output logic cmd_reject,
    output logic frame_short
);

    // ------------------------------------------------------------
    // state of the clock domain
    // ------------------------------------------------------------
    typedef struct packed {
        // crossing stages and frame bookkeeping
        logic cs_meta;
        logic cs_sync;
        logic cs_dly;
        logic cs_old;
        logic tgl_meta;
        logic tgl_sync;
        logic tgl_seen;
        logic pending;

        // registers the host can read back
        logic [15:0] preload_reg;
        logic [15:0] output_reg;
        logic swb;
        logic pd_float;
        logic pd_pull;
        logic [15:0] resp;

        // one cycle pulses
        logic upd;
        logic rej;
        logic short;
    } dsc_state_s;

    // chip select idles high, so its synchroniser does too
    localparam dsc_state_s STATE_RESET = '{
        cs_meta: 1'b1,
        cs_sync: 1'b1,
        cs_dly: 1'b1,
        cs_old: 1'b1,
        tgl_meta: 1'b0,
        tgl_sync: 1'b0,
        tgl_seen: 1'b0,
        pending: 1'b0,

        // registers as after power-up
        preload_reg: dsc_pkg::CODE_DEFAULT,
        output_reg: dsc_pkg::CODE_DEFAULT,
        swb: dsc_pkg::MODE_DEFAULT[dsc_pkg::MASK_CH0_BIT],
        pd_float: dsc_pkg::POWER_DEFAULT[dsc_pkg::FLOAT_CH0_BIT],
        pd_pull: dsc_pkg::POWER_DEFAULT[dsc_pkg::MASK_CH0_BIT],
        resp: dsc_pkg::RESP_DEFAULT,

        // no pulse out of reset
        upd: 1'b0,
        rej: 1'b0,
        short: 1'b0
    };

    dsc_state_s s_r, s_nxt;

    logic [23:0] link_word;
    logic link_tgl;
    logic [7:0] cmd;
    logic [15:0] payload;
    logic [4:0] grp;
    logic [2:0] chan;
    logic chan_ok;
    logic frame_close;
    logic frame_new;
    logic pend_now;
    logic [7:0] setup_byte;

    // ------------------------------------------------------------
    // link end on the serial clock
    // ------------------------------------------------------------
    // the response word is only touched a few cycles after select
    // rises, while the link clock stands still, so it reaches the
    // link side settled before the next frame's first edge
    dsc_serial_link u_link (
        .link_clk(sclk),
        .chip_select_n(chip_select_n),
        .mosi(mosi),
        .rst_n(rst_n),
        .resp(s_r.resp),
        .frame_word(link_word),
        .frame_tgl(link_tgl),
        .sdo(sdo),
        .sdo_oe(sdo_oe)
    );

    // ------------------------------------------------------------
    // field split of the held frame
    // ------------------------------------------------------------
    assign cmd = link_word[23:16]; // RULE_16
    assign payload = link_word[15:0]; // RULE_16
    assign grp = cmd[7:3];
    assign chan = cmd[2:0]; // RULE_01
    assign chan_ok = (chan == dsc_pkg::CHANNEL_ZERO); // RULE_03

    // frame end seen one stage late, giving the toggle time to land
    assign frame_close = s_r.cs_dly & ~s_r.cs_old;
    assign frame_new = (s_r.tgl_sync != s_r.tgl_seen);
    assign pend_now = s_r.pending | frame_new;

    // setup read-back layout, undefined bits read as zero
    always_comb begin
        setup_byte = 8'h00;
        setup_byte[dsc_pkg::CFG_WB_BIT] = s_r.swb; // RULE_13
        setup_byte[dsc_pkg::CFG_PULL_BIT] = s_r.pd_pull; // RULE_13
        setup_byte[dsc_pkg::CFG_FLOAT_BIT] = s_r.pd_float; // RULE_13
    end

    // ------------------------------------------------------------
    // command byte to operation
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        // setup commands
        OP_IDLE = 4'h0,
        OP_CLEAR = 4'h1,
        OP_TRANSFER = 4'h2,
        OP_MODE = 4'h3,
        OP_POWER = 4'h4,
        // store commands
        OP_BROADCAST = 4'h5,
        OP_STORE = 4'h6,
        OP_STORE_UPDATE = 4'h7,
        // reads and leftovers
        OP_READ_PRELOAD = 4'h8,
        OP_READ_SETUP = 4'h9,
        OP_READ_OUTPUT = 4'ha,
        OP_ABSENT = 4'hb,
        OP_REJECT = 4'hc
    } dsc_op_e;

    dsc_op_e op;

    // word or read aimed at a missing channel is a quiet no-op
    always_comb begin
        op = OP_REJECT;
        if (cmd == dsc_pkg::CMD_IDLE) begin
            op = OP_IDLE;
        end else if (cmd == dsc_pkg::CMD_CLEAR) begin
            op = OP_CLEAR;
        end else if (cmd == dsc_pkg::CMD_TRANSFER) begin
            op = OP_TRANSFER;
        end else if (cmd == dsc_pkg::CMD_MODE) begin
            op = OP_MODE;
        end else if (cmd == dsc_pkg::CMD_POWER_OFF) begin
            op = OP_POWER;
        end else if (cmd == dsc_pkg::CMD_BROADCAST_STORE) begin
            op = OP_BROADCAST;
        end else if (grp == dsc_pkg::GRP_STORE) begin
            op = chan_ok ? OP_STORE : OP_ABSENT; // RULE_03
        end else if (grp == dsc_pkg::GRP_STORE_UPDATE) begin
            op = chan_ok ? OP_STORE_UPDATE : OP_ABSENT; // RULE_03
        end else if (grp == dsc_pkg::GRP_READ_RESERVED) begin
            op = OP_REJECT; // RULE_12
        end else if (grp == dsc_pkg::GRP_PRELOAD_READBACK) begin
            op = chan_ok ? OP_READ_PRELOAD : OP_ABSENT; // RULE_03
        end else if (grp == dsc_pkg::GRP_SETUP_READBACK) begin
            op = chan_ok ? OP_READ_SETUP : OP_ABSENT; // RULE_03
        end else if (grp == dsc_pkg::GRP_OUTPUT_READBACK) begin
            op = chan_ok ? OP_READ_OUTPUT : OP_ABSENT; // RULE_03
        end
    end

    // ------------------------------------------------------------
    // next state: crossings, then command execution
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.upd = 1'b0;
        s_nxt.rej = 1'b0;
        s_nxt.short = 1'b0;

        // two stages each; the first stage feeds only the second
        s_nxt.cs_meta = chip_select_n;
        s_nxt.cs_sync = s_r.cs_meta;
        s_nxt.cs_dly = s_r.cs_sync;
        s_nxt.cs_old = s_r.cs_dly;
        s_nxt.tgl_meta = link_tgl;
        s_nxt.tgl_sync = s_r.tgl_meta;
        s_nxt.tgl_seen = s_r.tgl_sync;

        // a frame arriving as the last one is consumed is kept
        s_nxt.pending = pend_now;

        if (frame_close && !pend_now) begin
            s_nxt.short = 1'b1;
        end else if (frame_close) begin
            // set wins: a second frame landing now stays pending
            s_nxt.pending = s_r.pending & frame_new;
            // every command but idle answers zero; reads below overwrite it
            s_nxt.resp = dsc_pkg::RESP_DEFAULT; // RULE_17

            unique case (op)
                OP_IDLE: begin
                    // nothing to do, payload ignored
                    s_nxt.resp = s_r.resp; // RULE_04
                end

                OP_CLEAR: begin
                    // back to the state after power-up
                    s_nxt.preload_reg = STATE_RESET.preload_reg; // RULE_04
                    s_nxt.output_reg = STATE_RESET.output_reg; // RULE_04
                    s_nxt.swb = STATE_RESET.swb; // RULE_04
                    s_nxt.pd_float = STATE_RESET.pd_float; // RULE_04
                    s_nxt.pd_pull = STATE_RESET.pd_pull; // RULE_04
                    s_nxt.upd = 1'b1;
                end

                OP_TRANSFER: begin
                    // mask bits of absent channels fall away
                    if (payload[dsc_pkg::MASK_CH0_BIT]) begin // RULE_02
                        s_nxt.output_reg = s_r.preload_reg; // RULE_05
                        s_nxt.upd = 1'b1; // RULE_14
                    end
                end

                OP_MODE: begin
                    // only mask bit 0 has a channel
                    s_nxt.swb = payload[dsc_pkg::MASK_CH0_BIT]; // RULE_06
                end

                OP_POWER: begin
                    // pulldown wins when both bits ask for channel 0
                    s_nxt.pd_pull = payload[dsc_pkg::MASK_CH0_BIT]; // RULE_08
                    s_nxt.pd_float = payload[dsc_pkg::FLOAT_CH0_BIT]
                        & ~payload[dsc_pkg::MASK_CH0_BIT]; // RULE_08
                end

                OP_BROADCAST: begin
                    // all channels is just channel 0
                    s_nxt.preload_reg = payload; // RULE_11
                    s_nxt.output_reg = payload; // RULE_11
                    s_nxt.upd = 1'b1; // RULE_14
                end

                OP_STORE: begin
                    // mode decides if the output follows
                    s_nxt.preload_reg = payload; // RULE_09
                    if (!s_r.swb) begin
                        s_nxt.output_reg = payload; // RULE_10
                        s_nxt.upd = 1'b1; // RULE_14
                    end
                end

                OP_STORE_UPDATE: begin
                    // mode ignored, both take the word
                    s_nxt.preload_reg = payload; // RULE_11
                    s_nxt.output_reg = payload; // RULE_11
                    s_nxt.upd = 1'b1; // RULE_14
                end

                OP_READ_PRELOAD: begin
                    // answer leaves in the next frame
                    s_nxt.resp = s_r.preload_reg; // RULE_12
                end

                OP_READ_SETUP: begin
                    // undefined high bits read as zero
                    s_nxt.resp = {8'h00, setup_byte}; // RULE_12
                end

                OP_READ_OUTPUT: begin
                    // code as it stands now
                    s_nxt.resp = s_r.output_reg; // RULE_12
                end

                OP_ABSENT: begin
                    // far channel: nothing stored
                    s_nxt.resp = dsc_pkg::RESP_DEFAULT; // RULE_03
                end

                OP_REJECT: begin
                    // reserved read group and every unknown byte
                    s_nxt.rej = 1'b1; // RULE_12
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // power-down never gates this: link and registers stay live
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_r <= STATE_RESET; // RULE_07
        end else begin
            s_r <= s_nxt; // RULE_15
        end
    end

    // ------------------------------------------------------------
    // outputs, each straight from the state register
    // ------------------------------------------------------------
    assign code_out = s_r.output_reg;
    assign preload_out = s_r.preload_reg;
    assign write_block = s_r.swb;
    assign powerdown_float = s_r.pd_float;
    assign pulldown_powerdown_select = s_r.pd_pull;
    assign code_update = s_r.upd;
    assign cmd_reject = s_r.rej;
    assign frame_short = s_r.short;

endmodule

`default_nettype wire

// ---- design/dsc_pkg.sv ----
// shared constants of the serial command decoder
package dsc_pkg;

    // ----------------------------------------------------------------
    // frame geometry
    // ----------------------------------------------------------------
    localparam int FRAME_BITS = 24;
    localparam int CMD_W = 8;
    localparam int DATA_W = 16;
    localparam int CFG_W = 8;
    localparam logic [4:0] FRAME_LAST = 5'h17;
    localparam logic [4:0] FRAME_FULL = 5'h18;

    // ----------------------------------------------------------------
    // command bytes and command groups (upper five bits)
    // ----------------------------------------------------------------
    localparam logic [7:0] CMD_IDLE = 8'h00;
    localparam logic [7:0] CMD_CLEAR = 8'h01;
    localparam logic [7:0] CMD_TRANSFER = 8'h18;
    localparam logic [7:0] CMD_MODE = 8'h28;
    localparam logic [7:0] CMD_POWER_OFF = 8'h30;
    localparam logic [7:0] CMD_BROADCAST_STORE = 8'h20;
    localparam logic [4:0] GRP_STORE = 5'h01;
    localparam logic [4:0] GRP_STORE_UPDATE = 5'h02;
    localparam logic [4:0] GRP_READ_RESERVED = 5'h10;
    localparam logic [4:0] GRP_PRELOAD_READBACK = 5'h11;
    localparam logic [4:0] GRP_SETUP_READBACK = 5'h12;
    localparam logic [4:0] GRP_OUTPUT_READBACK = 5'h13;
    localparam logic [2:0] CHANNEL_ZERO = 3'h0;

    // ----------------------------------------------------------------
    // field positions and values after reset
    // ----------------------------------------------------------------
    localparam int MASK_CH0_BIT = 0;
    localparam int FLOAT_CH0_BIT = 8;
    localparam int CFG_WB_BIT = 2;
    localparam int CFG_PULL_BIT = 1;
    localparam int CFG_FLOAT_BIT = 0;
    localparam logic [15:0] MODE_DEFAULT = 16'h00ff;
    localparam logic [15:0] POWER_DEFAULT = 16'h0000;
    localparam logic [15:0] CODE_DEFAULT = 16'h0000;
    localparam logic [15:0] RESP_DEFAULT = 16'h0000;

endpackage

// ---- design/dsc_serial_link.sv ----
// serial link end: shifts frames in and the response out on the link clock
`timescale 1ns/1ps
`default_nettype none

module dsc_serial_link (
    input wire logic link_clk,
    input wire logic chip_select_n,
    input wire logic mosi,
    input wire logic rst_n,
    input wire logic [15:0] resp,
    output logic [23:0] frame_word,
    output logic frame_tgl,
    output logic sdo,
    output logic sdo_oe
);

    typedef struct packed {
        logic [4:0] cnt;
        logic [22:0] shift;
    } dsc_frame_s;

    typedef struct packed {
        logic [23:0] word;
        logic tgl;
    } dsc_hold_s;

    typedef struct packed {
        logic sdo;
        logic oe;
    } dsc_tx_s;

    dsc_frame_s f_r, f_nxt;
    dsc_hold_s h_r, h_nxt;
    dsc_tx_s t_r, t_nxt;
    logic [23:0] tx_word;

    // ------------------------------------------------------------
    // receive: msb first, 24th bit completes the frame
    // ------------------------------------------------------------
    // extra bits past the 24th are dropped, short frames never toggle
    always_comb begin
        f_nxt = f_r;
        h_nxt = h_r;
        if (f_r.cnt != dsc_pkg::FRAME_FULL) begin
            f_nxt.cnt = f_r.cnt + 5'h01;
            f_nxt.shift = {f_r.shift[21:0], mosi}; // RULE_16
        end
        if (f_r.cnt == dsc_pkg::FRAME_LAST) begin
            h_nxt.word = {f_r.shift, mosi}; // RULE_16
            h_nxt.tgl = ~h_r.tgl;
        end
    end

    // frame state ends with the frame's own select, no clock needed
    always_ff @(posedge link_clk or posedge chip_select_n) begin
        if (chip_select_n) begin
            f_r <= '0;
        end else begin
            f_r <= f_nxt;
        end
    end

    // held word and toggle survive between frames
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            h_r <= '0;
        end else begin
            h_r <= h_nxt;
        end
    end

    // ------------------------------------------------------------
    // transmit: previous response, status byte of zeros first
    // ------------------------------------------------------------
    // bit 23 is a zero pad, so the missing edge before the first
    // sample costs nothing
    assign tx_word = {8'h00, resp};

    always_comb begin
        t_nxt.oe = 1'b1;
        t_nxt.sdo = 1'b0;
        if (f_r.cnt < dsc_pkg::FRAME_FULL) begin
            t_nxt.sdo = tx_word[dsc_pkg::FRAME_LAST - f_r.cnt]; // RULE_17
        end
    end

    always_ff @(negedge link_clk or posedge chip_select_n) begin
        if (chip_select_n) begin
            t_r <= '0;
        end else begin
            t_r <= t_nxt;
        end
    end

    assign frame_word = h_r.word;
    assign frame_tgl = h_r.tgl;
    assign sdo = t_r.sdo;
    assign sdo_oe = t_r.oe;

endmodule

`default_nettype wire
